//--- common/scd_cfg.svh
// offsets, field positions, reset values and counts of the clock divider
`ifndef SCD_CFG_SVH
`define SCD_CFG_SVH
`define SCD_OFS_RCC 8'h00
`define SCD_OFS_EXT 8'h04
`define SCD_OFS_GATE 8'h08
`define SCD_OFS_STAT 8'h0C
`define SCD_BIT_BYP 11
`define SCD_BIT_PWRDN 13
`define SCD_BIT_PULSE_CLOCK_DIVIDER_LSB 17
`define SCD_BIT_USEPWM 20
`define SCD_BIT_USEDIV 22
`define SCD_BIT_DIV_LSB 23
`define SCD_BIT_OVR 31
`define SCD_RCC_RST 32'h07802800
`define SCD_EXT_RST 32'h07802800
`define SCD_GATE_RST 8'h00
`define SCD_LOCK_CNT 16'h1200
`define SCD_PLL_MHZ 400
`define SCD_CONV_MHZ 16
`define SCD_CONV_DIV (`SCD_PLL_MHZ / `SCD_CONV_MHZ)
`endif

//--- common/scd_pkg.sv
// types of the clock divider
package scd_pkg;
  // effective source and divider selection
  typedef struct packed {
    logic byp;
    logic pll_off;
    logic use_div;
    logic [5:0] div;
  } scd_sel_type;
  typedef enum logic [1:0] {LK_OFF, LK_WAIT, LK_READY} scd_lock_type;
endpackage

//--- rtl/scd_clock_divider.sv
// run-mode system clock divider, source select and peripheral gating
//
// Notes on behaviour
// - extended bypass, power-down and divisor fields win over primary fields when selected.
// - override bit in extended register picks which register governs.
// - system divisor divides PLL path or oscillator, chosen by bypass.
// - PLL output is halved before the system divisor.
// - primary divide ratio is the 4-bit code plus one.
// - PLL path codes below 3 reserved; reset code 0xF.
// - extended divisor is two bits wider, up to divide by 64.
// - extended divide ratio is the 6-bit code plus one.
// - extended bypass 0 picks PLL, 1 picks raw oscillator.
// - extended PLL codes 0 to 2 reserved; higher give 200/(code+1).
// - divider-use clear and PLL off gives undivided source.
// - converter clock fixed at 16 MHz, independent of divisor.
// - pulse-width clock is a synchronous division of system clock.
// - each peripheral gets system clock through its own gate.
// - PLL enabled and selected at once: stay on oscillator until stable.
// - lock timed by 0x1200 down count on main oscillator ticks.
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/1ns
`include "scd_cfg.svh"
module scd_clock_divider (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic osc_tick,
  input wire logic pll_tick,
  output logic pll_run,
  output logic sys_tick,
  output logic pwm_tick,
  output logic conv_tick,
  output logic [7:0] periph_tick
);
  // ==========================================================
  // register file and bus slave
  logic [31:0] rcc_r, rcc_nxt, ext_r, ext_nxt, prdata_r, prdata_nxt;
  logic [7:0] gate_r, gate_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic wr_c;
  scd_pkg::scd_sel_type sel_c;
  scd_pkg::scd_lock_type lock_st_r, lock_st_nxt;
  logic [15:0] lock_cnt_r, lock_cnt_nxt;
  logic act_src_r, act_src_nxt;
  logic [5:0] act_div_r, act_div_nxt, cnt_r, cnt_nxt, eff_div_c;
  logic half_r, half_nxt, src_c, bnd_c, term_c;
  logic sys_r, sys_nxt, pwm_r, pwm_nxt, conv_r, conv_nxt, run_r, run_nxt;
  logic [7:0] pwm_cnt_r, pwm_cnt_nxt, pwm_mask_c, per_r, per_nxt;
  logic [4:0] conv_cnt_r, conv_cnt_nxt;

  // one field picker serves both registers
  function automatic scd_pkg::scd_sel_type fn_sel(
    input logic [31:0] r, input logic wide);
    scd_pkg::scd_sel_type s;
    s.byp = r[`SCD_BIT_BYP];
    s.pll_off = r[`SCD_BIT_PWRDN];
    s.use_div = 1'b0;
    if (wide) s.div = r[`SCD_BIT_DIV_LSB +: 6];
    else s.div = {2'h0, r[`SCD_BIT_DIV_LSB +: 4]};
    return s;
  endfunction

  // override selection; divider-use stays in the primary register
  always_comb begin
    if (ext_r[`SCD_BIT_OVR]) sel_c = fn_sel(ext_r, 1'b1);
    else sel_c = fn_sel(rcc_r, 1'b0);
    sel_c.use_div = rcc_r[`SCD_BIT_USEDIV];
  end

  // writes land at the access edge; answer comes with zero wait
  always_comb begin
    wr_c = psel && penable && pready_r && pwrite;
    rcc_nxt = rcc_r;
    ext_nxt = ext_r;
    gate_nxt = gate_r;
    if (wr_c && paddr == `SCD_OFS_RCC) rcc_nxt = pwdata;
    if (wr_c && paddr == `SCD_OFS_EXT) ext_nxt = pwdata;
    if (wr_c && paddr == `SCD_OFS_GATE) gate_nxt = pwdata[7:0];
    pready_nxt = psel && !penable;
    pslverr_nxt = 1'b0;
    prdata_nxt = 32'h00000000;
    if (psel && !penable) begin
      unique case (paddr)
        `SCD_OFS_RCC: prdata_nxt = rcc_r;
        `SCD_OFS_EXT: prdata_nxt = ext_r;
        `SCD_OFS_GATE: prdata_nxt = {24'h000000, gate_r};
        `SCD_OFS_STAT: prdata_nxt = {23'h000000, act_div_r, act_src_r,
          lock_st_r == scd_pkg::LK_READY, run_r};
        default: pslverr_nxt = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rcc_r <= `SCD_RCC_RST;
      ext_r <= `SCD_EXT_RST;
      gate_r <= `SCD_GATE_RST;
      prdata_r <= 32'h00000000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else if (ce) begin
      rcc_r <= rcc_nxt;
      ext_r <= ext_nxt;
      gate_r <= gate_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // ==========================================================
  // PLL lock timer
  // the count runs on main oscillator ticks, so its length tracks the
  // crystal and not the bus clock
  always_comb begin
    lock_st_nxt = lock_st_r;
    lock_cnt_nxt = lock_cnt_r;
    run_nxt = !sel_c.pll_off;
    unique case (lock_st_r)
      scd_pkg::LK_OFF: if (!sel_c.pll_off) begin
        lock_st_nxt = scd_pkg::LK_WAIT;
        lock_cnt_nxt = `SCD_LOCK_CNT;
      end
      scd_pkg::LK_WAIT: begin
        if (sel_c.pll_off) lock_st_nxt = scd_pkg::LK_OFF;
        else if (lock_cnt_r == 16'h0000) lock_st_nxt = scd_pkg::LK_READY;
        else if (osc_tick) lock_cnt_nxt = lock_cnt_r - 16'h0001;
      end
      scd_pkg::LK_READY: if (sel_c.pll_off) lock_st_nxt = scd_pkg::LK_OFF;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_st_r <= scd_pkg::LK_OFF;
      lock_cnt_r <= 16'h0000;
      run_r <= 1'b0;
    end else if (ce) begin
      lock_st_r <= lock_st_nxt;
      lock_cnt_r <= lock_cnt_nxt;
      run_r <= run_nxt;
    end
  end

  // ==========================================================
  // source select and system divider
  // new settings are taken only at a period boundary, so a period is
  // never cut short; losing the PLL is the one forced early switch
  always_comb begin
    half_nxt = half_r ^ pll_tick;
    src_c = act_src_r ? (pll_tick && half_r) : osc_tick;
    term_c = src_c && (cnt_r == act_div_r);
    bnd_c = term_c;
    // undivided when neither the divider nor the PLL is in use
    if (!sel_c.use_div && (sel_c.byp || sel_c.pll_off)) eff_div_c = 6'h00;
    else eff_div_c = sel_c.div;
    act_src_nxt = act_src_r;
    act_div_nxt = act_div_r;
    cnt_nxt = cnt_r;
    if (bnd_c) begin
      // stay on the oscillator until the lock timer has expired
      act_src_nxt = !sel_c.byp && lock_st_r == scd_pkg::LK_READY;
      act_div_nxt = eff_div_c;
      cnt_nxt = 6'h00;
    end else if (src_c) begin
      cnt_nxt = cnt_r + 6'h01;
    end
    if (lock_st_r != scd_pkg::LK_READY) act_src_nxt = 1'b0;
    sys_nxt = term_c;
    per_nxt = {8{term_c}} & gate_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_r <= 1'b0;
      act_src_r <= 1'b0;
      act_div_r <= 6'h0F;
      cnt_r <= 6'h00;
      sys_r <= 1'b0;
      per_r <= 8'h00;
    end else if (ce) begin
      half_r <= half_nxt;
      act_src_r <= act_src_nxt;
      act_div_r <= act_div_nxt;
      cnt_r <= cnt_nxt;
      sys_r <= sys_nxt;
      per_r <= per_nxt;
    end
  end

  // ==========================================================
  // pulse-width and converter clocks
  // pulse-width ratio is a power of two counted in system ticks; the
  // converter runs off the raw PLL so divisor changes never reach it
  always_comb begin
    pwm_mask_c = 8'h00;
    if (rcc_r[`SCD_BIT_USEPWM])
      pwm_mask_c = 8'(({1'b0, 8'h02} << rcc_r[`SCD_BIT_PULSE_CLOCK_DIVIDER_LSB +: 3])
        - 9'h001);
    pwm_cnt_nxt = pwm_cnt_r;
    pwm_nxt = 1'b0;
    if (term_c) begin
      pwm_nxt = (pwm_cnt_r & pwm_mask_c) == pwm_mask_c;
      pwm_cnt_nxt = pwm_cnt_r + 8'h01;
    end
    conv_cnt_nxt = conv_cnt_r;
    conv_nxt = 1'b0;
    if (pll_tick) begin
      conv_nxt = conv_cnt_r == 5'(`SCD_CONV_DIV - 1);
      conv_cnt_nxt = conv_nxt ? 5'h00 : conv_cnt_r + 5'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_cnt_r <= 8'h00;
      pwm_r <= 1'b0;
      conv_cnt_r <= 5'h00;
      conv_r <= 1'b0;
    end else if (ce) begin
      pwm_cnt_r <= pwm_cnt_nxt;
      pwm_r <= pwm_nxt;
      conv_cnt_r <= conv_cnt_nxt;
      conv_r <= conv_nxt;
    end
  end

  // outputs, all straight from flip-flops
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign pll_run = run_r;
  assign sys_tick = sys_r;
  assign pwm_tick = pwm_r;
  assign conv_tick = conv_r;
  assign periph_tick = per_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_lock_block;
    ce && lock_st_r != scd_pkg::LK_READY |=> !act_src_r;
  endproperty
  a_lock_block: assert property (p_lock_block)
    else $error("PLL used before lock");

  property p_lock_load;
    ce && lock_st_r == scd_pkg::LK_OFF && !sel_c.pll_off
      |=> lock_st_r == scd_pkg::LK_WAIT && lock_cnt_r == `SCD_LOCK_CNT;
  endproperty
  a_lock_load: assert property (p_lock_load)
    else $error("lock timer not loaded");

  property p_wait_src;
    lock_st_r == scd_pkg::LK_WAIT |-> !act_src_r;
  endproperty
  a_wait_src: assert property (p_wait_src)
    else $error("switched to PLL while waiting");

  property p_cnt_bound;
    cnt_r <= act_div_r;
  endproperty
  a_cnt_bound: assert property (p_cnt_bound)
    else $error("divider count past ratio");

  property p_restart;
    ce && bnd_c |=> cnt_r == 6'h00 && act_div_r == $past(eff_div_c);
  endproperty
  a_restart: assert property (p_restart)
    else $error("divider not restarted");

  property p_glitch;
    ce && !bnd_c |=> $stable(act_div_r);
  endproperty
  a_glitch: assert property (p_glitch)
    else $error("divisor changed mid period");

  property p_sys_tick;
    ce && term_c |=> sys_tick ##1 (!$past(ce) || !sys_tick || $past(term_c));
  endproperty
  a_sys_tick: assert property (p_sys_tick)
    else $error("system tick missing");

  property p_conv;
    ce && pll_tick && conv_cnt_r == 5'(`SCD_CONV_DIV - 1)
      |=> conv_tick && conv_cnt_r == 5'h00;
  endproperty
  a_conv: assert property (p_conv)
    else $error("converter tick wrong");

  property p_pwm;
    $rose(pwm_tick) |-> $past(term_c);
  endproperty
  a_pwm: assert property (p_pwm)
    else $error("pulse tick without system tick");

  property p_gate;
    |periph_tick |-> sys_tick;
  endproperty
  a_gate: assert property (p_gate)
    else $error("peripheral tick without system tick");

  c_pll_used: cover property (act_src_r && sys_tick);
  c_ovr: cover property (ext_r[`SCD_BIT_OVR] && bnd_c && act_div_r > 6'h0F);
  c_err: cover property (pready && pslverr);
endmodule

//--- tb/tb_system_clock_divider_select.sv
// testbench of the run clock divider: register access and tick rates
`timescale 1ns/1ns
`include "scd_cfg.svh"
module tb_system_clock_divider_select;
  logic pclk, presetn, ce, psel, penable, pwrite, osc_tick, pll_tick;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, pll_run, sys_tick, pwm_tick, conv_tick, err;
  logic [7:0] periph_tick;
  logic [31:0] c;
  logic [31:0] c_tab [3] = '{32'h0, 32'h5, 32'hF};
  logic [31:0] w_tab [2] = '{32'h9, 32'h3F};
  int n_mismatch = 0;
  int check_count = 0;

  scd_clock_divider i_scd_clock_divider (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .osc_tick(osc_tick),
    .pll_tick(pll_tick),
    .pll_run(pll_run),
    .sys_tick(sys_tick),
    .pwm_tick(pwm_tick),
    .conv_tick(conv_tick),
    .periph_tick(periph_tick)
  );

  // ==========================================================
  // clock and watchdog
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // the whole run needs under 7000 cycles; a hang ends it as a failure
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    $display("Error watchdog expected done seen hang");
    stop_test();
  end

  // ==========================================================
  // shared tasks
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one apb transfer; the request stands until pready is seen high at a
  // rising edge, and read data is taken at that very edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (pready !== 1'b1) begin
      n_mismatch++;
      $display("Error pready expected 1 seen %b", pready);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a,
                       input logic [31:0] exp, input logic exp_err);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rd);
    chk({nm, "_err"}, {31'h0, exp_err}, {31'h0, err});
  endtask

  function automatic logic tk(input int s);
    case (s)
      0: return sys_tick;
      1: return pwm_tick;
      default: return conv_tick;
    endcase
  endfunction

  // last of three periods, so a divisor change in flight has settled
  task automatic measure(input int s, input logic [31:0] exp,
                         input string nm);
    int n;
    for (int k = 0; k < 3; k++) begin
      n = 0;
      do begin
        @(negedge pclk);
        n++;
      end while (!tk(s) && n < 2000);
    end
    chk(nm, exp, n);
  endtask

  // ==========================================================
  // test sequence
  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    osc_tick = 1'b1;
    pll_tick = 1'b1;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("primary", `SCD_OFS_RCC, `SCD_RCC_RST, 1'b0);
    rdchk("ext", `SCD_OFS_EXT, `SCD_EXT_RST, 1'b0);
    rdchk("gate", `SCD_OFS_GATE, 32'h0, 1'b0);
    rdchk("unmapped", 8'h10, 32'h0, 1'b1);
    apb(1'b1, 8'h10, 32'hFFFFFFFF);
    chk("unmapped_wr_err", 32'h1, {31'h0, err});
    apb(1'b0, `SCD_OFS_STAT, 32'h0);
    chk("status", 32'h0, rd & 32'h7);
    measure(0, 1, "sys undivided");
    measure(2, 25, "conv");
    $display("test reset done");
    // primary divisor on the oscillator, codes at both ends
    foreach (c_tab[i]) begin
      c = c_tab[i];
      apb(1'b1, `SCD_OFS_RCC, 32'h00402800 | (c << 23));
      measure(0, c + 1, "sys primary");
    end
    // wide divisor overrides the primary one
    foreach (w_tab[i]) begin
      c = w_tab[i];
      apb(1'b1, `SCD_OFS_EXT, 32'h80002800 | (c << 23));
      measure(0, c + 1, "sys wide");
    end
    apb(1'b1, `SCD_OFS_EXT, 32'h00002800);
    measure(0, 16, "sys no override");
    $display("test divisor done");
    // pll enabled and selected in one write: oscillator until lock
    apb(1'b1, `SCD_OFS_EXT, 32'h81800000);
    measure(0, 4, "sys locking");
    apb(1'b0, `SCD_OFS_STAT, 32'h0);
    chk("status locking", 32'h1, rd & 32'h7);
    chk("pll_run", 32'h1, {31'h0, pll_run});
    repeat (4500) @(posedge pclk);
    apb(1'b0, `SCD_OFS_STAT, 32'h0);
    chk("status early", 32'h1, rd & 32'h7);
    repeat (200) @(posedge pclk);
    apb(1'b0, `SCD_OFS_STAT, 32'h0);
    chk("status locked", 32'h7, rd & 32'h7);
    measure(0, 8, "sys pll");
    measure(2, 25, "conv pll");
    $display("test pll done");
    // pulse-width divide and peripheral gates on the oscillator
    apb(1'b1, `SCD_OFS_EXT, 32'h00002800);
    apb(1'b1, `SCD_OFS_RCC, 32'h00D22800);
    measure(1, 8, "pwm");
    apb(1'b1, `SCD_OFS_GATE, 32'h5);
    rdchk("gate back", `SCD_OFS_GATE, 32'h5, 1'b0);
    repeat (40) begin
      @(negedge pclk);
      chk("periph", {29'h0, sys_tick, 1'b0, sys_tick}, periph_tick);
    end
    $display("test pwm and gates done");
    stop_test();
  end
endmodule
